//--- gpm_consts.svh
// Constants of the shared-pin general-purpose port: offsets, fields, resets
// Summary of operation
// - Each shared pin follows its own select bit, zero giving the peripheral function and one the port bit.
// - Select bits 0 and 1 go with address lines 20 and 21, bits 2 and 3 with timer in and out, bits 4 to 7 with TxD, RxD, CTS and RTS.
// - Every pin can be moved to port use on its own while its sibling pins stay with their peripheral.
// - A peripheral input whose pin is in port use is fed a fixed level suited to it, without disturbing the port pin.
// - A peripheral with all its pins in port use keeps running, just without outside stimulus.
// - A pin in port use is an input while its direction bit is clear and an output while it is set.
// - Reset clears all direction and select bits so every pin comes up as a peripheral pin.
// - Writes to the data register with byte lane 0 enabled land in the output latch, which never reaches a pin set as input.
// - An output pin is driven from its latch bit and reads back the latch bit.
// - An input pin reads back the level present on the pin, not the latch.
// - The data register may be written at any time and reading input pins never alters the latch.
// - Turning a pin from input to output drives the value already held in its latch at once.
`ifndef GPM_CONSTS_SVH
`define GPM_CONSTS_SVH

// Port and bus widths
`define GPM_PORT_W      8
`define GPM_ADDR_W      12
`define GPM_DATA_W      32

// Register indices; the byte address is four times the index
`define GPM_IDX_SELECT  10'h1C1
`define GPM_IDX_DIR     10'h1C5
`define GPM_IDX_DATA    10'h1C9

// Reset values
`define GPM_SEL_RST     8'h00
`define GPM_DIR_RST     8'h00
`define GPM_RD_ZERO     32'h0000_0000

// Pin positions
`define GPM_PIN_ADDR_LO 0
`define GPM_PIN_ADDR_HI 1
`define GPM_PIN_TMR_IN  2
`define GPM_PIN_TMR_OUT 3
`define GPM_PIN_TXD     4
`define GPM_PIN_RXD     5
`define GPM_PIN_CTS     6
`define GPM_PIN_RTS     7

// Pins that are peripheral inputs, and the level each is tied to
`define GPM_IN_MASK     8'h64
`define GPM_TIE_LEVELS  8'h60

`endif

//--- gpm_pkg.sv
// Types shared by the shared-pin port design
package gpm_pkg;

   // Bus slave states, one-hot
   typedef enum logic [1:0] {
      GPM_ST_IDLE = 2'b01,
      GPM_ST_ACK  = 2'b10
   } gpm_bus_state_e;

   // Which register an access hits
   typedef enum logic [3:0] {
      GPM_SEL_NONE = 4'b0001,
      GPM_SEL_FUNC = 4'b0010,
      GPM_SEL_DIR  = 4'b0100,
      GPM_SEL_DATA = 4'b1000
   } gpm_reg_sel_e;

   // Word-aligned hit test of a byte address against a register index
   function automatic logic reg_hit(input logic [11:0] paddr,
                                    input logic [9:0]  idx);
      return paddr == {idx, 2'b00};
   endfunction

endpackage

//--- gpm_apb_slave.sv
// APB handshake: one wait state, then a single-cycle pready
`timescale 1ns/10ps
module gpm_apb_slave (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // APB control
   input  wire logic psel,
   input  wire logic penable,
   input  wire logic pwrite,
   // Handshake out
   output logic      pready,
   output logic      rd_capture,
   output logic      wr_commit
);

   gpm_pkg::gpm_bus_state_e state_q;
   gpm_pkg::gpm_bus_state_e state_d;

   // One wait state gives a full cycle to register read data
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         gpm_pkg::GPM_ST_IDLE: begin
            if (psel && penable) begin
               state_d = gpm_pkg::GPM_ST_ACK;
            end
         end
         gpm_pkg::GPM_ST_ACK: begin
            state_d = gpm_pkg::GPM_ST_IDLE;
         end
         default: begin
            state_d = gpm_pkg::GPM_ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= gpm_pkg::GPM_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Strobes toward the register file
   assign pready     = (state_q == gpm_pkg::GPM_ST_ACK) && psel && penable;
   assign rd_capture = (state_q == gpm_pkg::GPM_ST_IDLE) && psel && penable
                       && !pwrite;
   assign wr_commit  = pready && pwrite;

endmodule // gpm_apb_slave

//--- gpm_pin_cell.sv
// One shared pin: peripheral or port routing, input tie, read-back bit
`timescale 1ns/10ps
module gpm_pin_cell #(
   parameter logic IS_INPUT  = 1'b0,
   parameter logic TIE_LEVEL = 1'b0
) (
   // Configuration
   input  wire logic sel,
   input  wire logic dir,
   input  wire logic latch,
   // Peripheral side
   input  wire logic periph_out,
   input  wire logic periph_oe,
   output logic      periph_in,
   // Pad side
   input  wire logic pad_in,
   output logic      pad_out,
   output logic      pad_oe,
   // Read-back
   output logic      rd_bit
);

   // Port use follows the direction bit, peripheral use its own enable
   assign pad_oe  = sel ? dir : (periph_oe && !IS_INPUT);
   // Drive zero whenever the pad is released so the latch never leaks
   assign pad_out = pad_oe && (sel ? latch : periph_out);

   // Peripheral keeps running on a fixed level when the pin is taken
   assign periph_in = sel ? TIE_LEVEL : pad_in;

   // Outputs read the latch, inputs read the live pin
   assign rd_bit = (sel && dir) ? latch : pad_in;

endmodule // gpm_pin_cell

//--- gpm_port.sv
// Shared-pin general-purpose port with APB register access
`timescale 1ns/10ps
`include "gpm_consts.svh"
module gpm_port #(
   parameter int PORT_W = `GPM_PORT_W
) (
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`GPM_ADDR_W-1:0] paddr,
   input  wire logic [`GPM_DATA_W-1:0] pwdata,
   input  wire logic [3:0]             pstrb,
   output logic      [`GPM_DATA_W-1:0] prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Address core, dedicated outputs
   input  wire logic                   upper_address_line_twenty,
   input  wire logic                   upper_address_line_twentyone,
   // Timer
   input  wire logic                   timer_output_pin,
   output logic                        timer_input_pin,
   // Serial port
   input  wire logic                   txd_from_uart,
   input  wire logic                   rts_n_from_uart,
   output logic                        rxd_to_uart,
   output logic                        cts_n_to_uart,
   // Shared pads
   input  wire logic [PORT_W-1:0]      pad_in,
   output logic      [PORT_W-1:0]      pad_out,
   output logic      [PORT_W-1:0]      pad_oe
);

   // Configuration registers
   logic [PORT_W-1:0]      pin_function_select_q;
   logic [PORT_W-1:0]      port_direction_q;
   logic [PORT_W-1:0]      port_data_latch_q;
   logic [`GPM_DATA_W-1:0] prdata_q;

   // Bus strobes
   logic                   rd_capture;
   logic                   wr_commit;
   gpm_pkg::gpm_reg_sel_e  reg_sel;

   // Per-pin routing vectors
   logic [PORT_W-1:0]      periph_out_vec;
   logic [PORT_W-1:0]      periph_oe_vec;
   logic [PORT_W-1:0]      periph_in_vec;
   logic [PORT_W-1:0]      rd_vec;
   logic [PORT_W-1:0]      wr_byte;

   // Handshake timing lives in a small slave
   gpm_apb_slave u_apb (
      .pclk       (pclk),
      .presetn    (presetn),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .pready     (pready),
      .rd_capture (rd_capture),
      .wr_commit  (wr_commit)
   );

   // Address decode shared by reads and writes
   always_comb begin
      if (gpm_pkg::reg_hit(paddr, `GPM_IDX_SELECT)) begin
         reg_sel = gpm_pkg::GPM_SEL_FUNC;
      end else if (gpm_pkg::reg_hit(paddr, `GPM_IDX_DIR)) begin
         reg_sel = gpm_pkg::GPM_SEL_DIR;
      end else if (gpm_pkg::reg_hit(paddr, `GPM_IDX_DATA)) begin
         reg_sel = gpm_pkg::GPM_SEL_DATA;
      end else begin
         reg_sel = gpm_pkg::GPM_SEL_NONE;
      end
   end

   // Unmapped words answer with an error, never a silent write
   assign pslverr = pready && (reg_sel == gpm_pkg::GPM_SEL_NONE);

   // Only lane 0 carries data; a write with that lane off stores nothing
   assign wr_byte = pwdata[PORT_W-1:0];

   // Function select: each bit stands alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_function_select_q <= `GPM_SEL_RST;
      end else if (wr_commit && pstrb[0]
                   && reg_sel == gpm_pkg::GPM_SEL_FUNC) begin
         pin_function_select_q <= wr_byte;
      end
   end

   // Direction bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_direction_q <= `GPM_DIR_RST;
      end else if (wr_commit && pstrb[0]
                   && reg_sel == gpm_pkg::GPM_SEL_DIR) begin
         port_direction_q <= wr_byte;
      end
   end

   // Output latch: no reset, so software loads it before enabling outputs
   always_ff @(posedge pclk) begin
      if (wr_commit && pstrb[0]
          && reg_sel == gpm_pkg::GPM_SEL_DATA) begin
         port_data_latch_q <= wr_byte;
      end
   end

   // Read data is registered in the wait state, a cycle before pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= `GPM_RD_ZERO;
      end else if (rd_capture) begin
         unique case (reg_sel)
            gpm_pkg::GPM_SEL_FUNC: begin
               prdata_q <= {{(`GPM_DATA_W-PORT_W){1'b0}},
                            pin_function_select_q};
            end
            gpm_pkg::GPM_SEL_DIR: begin
               prdata_q <= {{(`GPM_DATA_W-PORT_W){1'b0}},
                            port_direction_q};
            end
            gpm_pkg::GPM_SEL_DATA: begin
               prdata_q <= {{(`GPM_DATA_W-PORT_W){1'b0}}, rd_vec};
            end
            gpm_pkg::GPM_SEL_NONE: begin
               prdata_q <= `GPM_RD_ZERO;
            end
         endcase
      end
   end

   assign prdata = prdata_q;

   // Dedicated functions on each pin; inputs never drive their pad
   always_comb begin
      periph_out_vec = {PORT_W{1'b0}};
      periph_oe_vec  = ~`GPM_IN_MASK;
      periph_out_vec[`GPM_PIN_ADDR_LO] = upper_address_line_twenty;
      periph_out_vec[`GPM_PIN_ADDR_HI] = upper_address_line_twentyone;
      periph_out_vec[`GPM_PIN_TMR_OUT] = timer_output_pin;
      periph_out_vec[`GPM_PIN_TXD]  = txd_from_uart;
      periph_out_vec[`GPM_PIN_RTS]  = rts_n_from_uart;
   end

   // Inputs handed back to the peripherals, tied when the pin is taken
   assign timer_input_pin = periph_in_vec[`GPM_PIN_TMR_IN];
   assign rxd_to_uart     = periph_in_vec[`GPM_PIN_RXD];
   assign cts_n_to_uart   = periph_in_vec[`GPM_PIN_CTS];

   // One cell per pin; tie level comes from the pin's function
   for (genvar i = 0; i < PORT_W; i++) begin : g_pin
      gpm_pin_cell #(
         .IS_INPUT  (1'(`GPM_IN_MASK >> i)),
         .TIE_LEVEL (1'(`GPM_TIE_LEVELS >> i))
      ) u_cell (
         .sel        (pin_function_select_q[i]),
         .dir        (port_direction_q[i]),
         .latch      (port_data_latch_q[i]),
         .periph_out (periph_out_vec[i]),
         .periph_oe  (periph_oe_vec[i]),
         .periph_in  (periph_in_vec[i]),
         .pad_in     (pad_in[i]),
         .pad_out    (pad_out[i]),
         .pad_oe     (pad_oe[i]),
         .rd_bit     (rd_vec[i])
      );
   end

   // Checks on the routing and the register file
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Helper masks for the checks
   logic [PORT_W-1:0] port_out_m;
   logic [PORT_W-1:0] port_in_m;
   assign port_out_m = pin_function_select_q & port_direction_q;
   assign port_in_m  = pin_function_select_q & ~port_direction_q;

   // Access phase waits exactly one cycle before pready
   sequence s_access_start;
      psel && penable && !pready;
   endsequence
   sequence s_access_done;
      psel && penable && pready;
   endsequence

   a_ready_one_wait: assert property (
      s_access_start |=> s_access_done)
      else $error("pready did not follow one cycle into access");

   a_reset_clears_cfg: assert property (
      $rose(presetn) |-> (pin_function_select_q == `GPM_SEL_RST)
                         && (port_direction_q == `GPM_DIR_RST))
      else $error("select or direction not cleared by reset");

   a_select_write_lands: assert property (
      (wr_commit && pstrb[0] && reg_sel == gpm_pkg::GPM_SEL_FUNC)
      |=> pin_function_select_q == $past(wr_byte))
      else $error("function select write lost");

   a_pad_enable_route: assert property (
      pad_oe == ((~pin_function_select_q & ~`GPM_IN_MASK)
                 | port_out_m))
      else $error("pad enable does not follow select and direction");

   a_input_latch_hidden: assert property (
      (pad_oe & port_in_m) == {PORT_W{1'b0}})
      else $error("latch reaches a pin set as input");

   a_output_from_latch: assert property (
      ((pad_out ^ port_data_latch_q) & port_out_m) == {PORT_W{1'b0}})
      else $error("output pin differs from its latch");

   a_input_read_pin: assert property (
      (rd_capture && reg_sel == gpm_pkg::GPM_SEL_DATA)
      |=> ((prdata[PORT_W-1:0] ^ $past(pad_in)) & $past(port_in_m))
          == {PORT_W{1'b0}})
      else $error("input bit did not read the pin level");

   a_read_keeps_latch: assert property (
      (rd_capture && reg_sel == gpm_pkg::GPM_SEL_DATA)
      ##1 s_access_done |=> $stable(port_data_latch_q))
      else $error("read altered the output latch");

   a_turn_on_drives: assert property (
      (port_out_m & ~$past(port_direction_q)) != {PORT_W{1'b0}}
      |-> ((pad_out ^ port_data_latch_q) & port_out_m
           & ~$past(port_direction_q)) == {PORT_W{1'b0}})
      else $error("newly enabled output not driving latch");

   a_tie_taken_inputs: assert property (
      pin_function_select_q[`GPM_PIN_RXD]
      |-> rxd_to_uart == 1'(`GPM_TIE_LEVELS >> `GPM_PIN_RXD))
      else $error("serial receive input not tied");

   a_timer_tie_low: assert property (
      pin_function_select_q[`GPM_PIN_TMR_IN] |-> !timer_input_pin)
      else $error("timer input not tied when pin taken");

   a_periph_pass: assert property (
      !pin_function_select_q[`GPM_PIN_ADDR_LO]
      |-> pad_out[`GPM_PIN_ADDR_LO] == upper_address_line_twenty)
      else $error("address line not on its pin");

   a_cts_tie_high: assert property (
      pin_function_select_q[`GPM_PIN_CTS] |-> cts_n_to_uart)
      else $error("clear-to-send input not tied when pin taken");

   a_rx_from_pin: assert property (
      !pin_function_select_q[`GPM_PIN_RXD]
      |-> rxd_to_uart == pad_in[`GPM_PIN_RXD])
      else $error("serial receive input not taken from its pin");

   a_upper_line_pin: assert property (
      !pin_function_select_q[`GPM_PIN_ADDR_HI]
      |-> pad_out[`GPM_PIN_ADDR_HI] == upper_address_line_twentyone)
      else $error("upper address line not on its pin");

   a_timer_out_pin: assert property (
      !pin_function_select_q[`GPM_PIN_TMR_OUT]
      |-> pad_out[`GPM_PIN_TMR_OUT] == timer_output_pin)
      else $error("timer output not on its pin");

   a_tx_on_pin: assert property (
      !pin_function_select_q[`GPM_PIN_TXD]
      |-> pad_oe[`GPM_PIN_TXD] && pad_out[`GPM_PIN_TXD] == txd_from_uart)
      else $error("serial transmit output not on its pin");

   a_rts_on_pin: assert property (
      !pin_function_select_q[`GPM_PIN_RTS]
      |-> pad_out[`GPM_PIN_RTS] == rts_n_from_uart)
      else $error("request-to-send output not on its pin");

   a_timer_in_free: assert property (
      !pin_function_select_q[`GPM_PIN_TMR_IN] |-> !pad_oe[`GPM_PIN_TMR_IN])
      else $error("timer input pin driven in peripheral use");

   a_dir_write_lands: assert property (
      (wr_commit && pstrb[0] && reg_sel == gpm_pkg::GPM_SEL_DIR)
      |=> port_direction_q == $past(wr_byte))
      else $error("direction write lost");

   a_latch_write_lands: assert property (
      (wr_commit && pstrb[0] && reg_sel == gpm_pkg::GPM_SEL_DATA)
      |=> port_data_latch_q == $past(wr_byte))
      else $error("data write did not reach the latch");

   a_lane_off_keeps: assert property (
      (wr_commit && !pstrb[0]) |=> $stable(port_data_latch_q))
      else $error("write with lane 0 off changed the latch");

   a_ready_single: assert property (
      s_access_done |=> !pready)
      else $error("pready stood for more than one cycle");

endmodule // gpm_port

//--- gpm_board.sv
// Board model: drives released shared pads and reads back driven ones
`timescale 1ns/10ps
module gpm_board (
   // Pads from the port
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   // Level the board puts on each pad while the port lets it go
   input  wire logic [7:0] ext_level,
   // Pad levels seen by the port
   output logic      [7:0] pad_in
);
   // A driven pad shows the port's value; others follow the board source
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_level[i];
      end
   end
endmodule // gpm_board

//--- gpm_port_bench.sv
// Self-checking bench of the shared-pin port against a bit-level model
`timescale 1ns/10ps
`include "gpm_consts.svh"
module gpm_port_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        addr_lo, addr_hi, tmr_out, txd, rts_n, tmr_in, rxd, cts_n;
   logic [7:0]  pad_in, pad_out, pad_oe, ext;
   int          fail_count, checked, sel_m, dir_m, lat_m;
   logic [31:0] rd;
   logic        err;

   gpm_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .upper_address_line_twenty(addr_lo),
      .upper_address_line_twentyone(addr_hi),
      .timer_output_pin(tmr_out), .timer_input_pin(tmr_in),
      .txd_from_uart(txd), .rts_n_from_uart(rts_n), .rxd_to_uart(rxd),
      .cts_n_to_uart(cts_n), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe));
   gpm_board board (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext),
      .pad_in(pad_in));

   // Free-running 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic results;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, exp, input string what);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One APB transfer; an idle edge first keeps psel from double updates
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
      paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) begin
         fail_count++;
         results();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // Load all three registers, mirroring them in the model
   task automatic setup(input int s, input int d, input int l);
      apb(1'b1, 12'h724, 32'(l & 8'hFF), 4'hF);
      apb(1'b1, 12'h704, 32'(s & 8'hFF), 4'hF);
      apb(1'b1, 12'h714, 32'(d & 8'hFF), 4'hF);
      sel_m = s; dir_m = d; lat_m = l;
   endtask

   // Compare pads, tied peripheral inputs and data read-back with the model
   task automatic check_pins;
      logic [7:0] oe, out, lv, pv, rd8, tie, inm;
      tie = `GPM_TIE_LEVELS;
      inm = `GPM_IN_MASK;
      pv = {rts_n, 2'b00, txd, tmr_out, 1'b0, addr_hi, addr_lo};
      for (int i = 0; i < 8; i++) begin
         oe[i]  = sel_m[i] ? dir_m[i] : !inm[i];
         out[i] = oe[i] ? (sel_m[i] ? lat_m[i] : pv[i]) : 1'b0;
         lv[i]  = oe[i] ? out[i] : ext[i];
         rd8[i] = (sel_m[i] & dir_m[i]) ? lat_m[i] : lv[i];
      end
      @(posedge pclk);
      chk(32'(pad_oe), 32'(oe), "pad enables");
      chk(32'(pad_out), 32'(out), "pad drive");
      chk(32'(tmr_in), 32'(sel_m[2] ? tie[2] : lv[2]), "timer in");
      chk(32'(rxd), 32'(sel_m[5] ? tie[5] : lv[5]), "rx in");
      chk(32'(cts_n), 32'(sel_m[6] ? tie[6] : lv[6]), "cts in");
      apb(1'b0, 12'h724, 32'h0, 4'h0);
      chk(rd, {24'h000000, rd8}, "data read");
   endtask

   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {addr_lo, addr_hi, tmr_out, txd, rts_n} = 5'h13;
      ext = 8'hA5;
      fail_count = 0; checked = 0; sel_m = 0; dir_m = 0; lat_m = 0;
      presetn = 1'b0;
      void'($urandom(32'hDAE156E0));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h704, 32'h0, 4'h0);
      chk(rd, 32'(`GPM_SEL_RST), "select reset");
      apb(1'b0, 12'h714, 32'h0, 4'h0);
      chk(rd, 32'(`GPM_DIR_RST), "direction reset");
      // Latch has no reset; load it before the first data read
      apb(1'b1, 12'h724, 32'h0, 4'h1);
      check_pins();
      apb(1'b0, 12'h700, 32'h0, 4'h0);
      chk({31'h0, err}, 32'h1, "unmapped error");
      chk(rd, `GPM_RD_ZERO, "unmapped data");
      // Latch loaded while inputs, then outputs turned on
      setup(8'hFF, 8'h00, 8'h3C);
      apb(1'b1, 12'h724, 32'hC3, 4'h1);
      lat_m = 8'hC3;
      // Lane 0 off: the write is dropped and the latch keeps its value
      apb(1'b1, 12'h724, 32'h5A, 4'h0);
      check_pins();
      apb(1'b1, 12'h714, 32'hFF, 4'hF);
      dir_m = 8'hFF;
      check_pins();
      // Random mixes of port and peripheral pins
      for (int k = 0; k < 24; k++) begin
         ext <= 8'($urandom);
         {addr_lo, addr_hi, tmr_out, txd, rts_n} <= 5'($urandom);
         setup($urandom & 8'hFF, $urandom & 8'hFF, $urandom & 8'hFF);
         check_pins();
         apb(1'b0, 12'h704, 32'h0, 4'h0);
         chk(rd, 32'(sel_m & 8'hFF), "select readback");
         apb(1'b0, 12'h714, 32'h0, 4'h0);
         chk(rd, 32'(dir_m & 8'hFF), "direction readback");
      end
      // Reset in mid-run: configuration clears, the latch keeps its value
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      sel_m = 0;
      dir_m = 0;
      apb(1'b0, 12'h704, 32'h0, 4'h0);
      chk(rd, 32'(`GPM_SEL_RST), "select after reset");
      apb(1'b0, 12'h714, 32'h0, 4'h0);
      chk(rd, 32'(`GPM_DIR_RST), "direction after reset");
      check_pins();
      results();
   end
endmodule // gpm_port_bench
